//--- src/asop_top.sv
`timescale 1ns/1ps
`default_nettype none

module asop_top
    import asop_pkg::*;
(
    // Clock and reset.
    input  wire logic             CLK,
    input  wire logic             RST_N,
    // Conversion engine, same clock domain.
    input  wire logic             BUSY,
    input  wire logic [RES_W-1:0] RESULT,
    // Configuration and host strobe pins.
    input  wire logic             PORT_TYPE_SELECT,
    input  wire logic             OUTPUT_CODE_SELECT,
    input  wire logic             CS_N,
    input  wire logic             RD_N,
    // Shared pins for result bits 4 to 8.
    input  wire logic [PIN_W-1:0] PIN_D_IN,
    output logic      [PIN_W-1:0] PIN_D_OUT,
    output logic      [PIN_W-1:0] PIN_D_OE,
    // Serial bit clock pin.
    input  wire logic             SCLK_IN,
    output logic                  SCLK_OUT,
    output logic                  SCLK_OE,
    // Serial status pins.
    output logic                  FRAME_SYNC,
    output logic                  READ_OVERRUN_FLAG
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release and input synchronisers.

    logic             rst_meta;
    logic             rst_n_sync;
    logic [SYN_W-1:0] in_meta;
    logic [SYN_W-1:0] in_sync;
    logic [SYN_W-1:0] in_raw;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta   <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_n_sync <= rst_meta;
        end
    end

    assign in_raw = {SCLK_IN, RD_N, CS_N, OUTPUT_CODE_SELECT, PORT_TYPE_SELECT,
                     PIN_D_IN[PIN_CHAIN:PIN_CLKSRC]};

    always_ff @(posedge CLK or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            in_meta <= SYN_RST;
            in_sync <= SYN_RST;
        end else begin
            in_meta <= in_raw;
            in_sync <= in_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Decoded controls and events.

    wire serial_mode = in_sync[SYN_PORTSEL];
    wire ext_clk     = in_sync[PIN_CLKSRC];
    wire frm_pol     = in_sync[PIN_FRMPOL];
    wire clk_inv     = in_sync[PIN_CLKINV];
    wire chain_rdc   = in_sync[PIN_CHAIN];
    wire code_sel    = in_sync[SYN_CODE];
    wire sclk_s      = in_sync[SYN_SCLK];
    wire read_en     = ~in_sync[SYN_CS_N] & ~in_sync[SYN_RD_N];
    wire master      = serial_mode & ~ext_clk;
    wire slave       = serial_mode & ext_clk;

    logic busy_prev;
    logic sclk_prev;

    wire busy_fall = busy_prev & ~BUSY;
    wire busy_rise = ~busy_prev & BUSY;
    wire sclk_rise = ~sclk_prev & sclk_s;
    wire sclk_fall = sclk_prev & ~sclk_s;

    // Chip select gates the host clock, so edges outside a read are ignored.
    wire launch_ext = slave & read_en & (clk_inv ? sclk_fall : sclk_rise);

    // The MSB is inverted for twos complement when code select is low.
    wire [RES_W-1:0] coded = {RESULT[RES_W-1] ^ ~code_sel, RESULT[RES_W-2:0]};

    always_ff @(posedge CLK or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            busy_prev <= 1'b0;
            sclk_prev <= 1'b0;
        end else begin
            busy_prev <= BUSY;
            sclk_prev <= sclk_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Stored result, latched as the conversion ends.

    logic [RES_W-1:0] held;

    always_ff @(posedge CLK or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            held <= RESULT_RST;
        end else if (busy_fall) begin
            held <= coded;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Internal clock frame sequencer.

    asop_state_t state;
    asop_state_t next_state;
    logic        pending;
    logic [1:0]  phase;
    logic [4:0]  bit_cnt;
    logic        sclk_int;

    // Read during conversion starts on the rising edge of busy, using the previous result.
    wire trigger_int = master & (chain_rdc ? busy_rise : busy_fall);
    wire start_int   = (state == ST_IDLE) & pending & read_en & master;
    wire bit_end     = (state == ST_SHIFT) & (phase == PH_LAST);
    wire frame_end   = bit_end & (bit_cnt == LAST_BIT);
    wire shift_int   = bit_end & ~frame_end;

    always_comb begin
        case (state)
            ST_IDLE:  next_state = start_int ? ST_SHIFT : ST_IDLE;
            ST_SHIFT: next_state = (frame_end | ~master) ? ST_IDLE : ST_SHIFT;
            default:  next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            state   <= ST_IDLE;
            pending <= 1'b0;
        end else begin
            state   <= next_state;
            pending <= trigger_int | (pending & ~start_int);
        end
    end

    // Data moves only at the last phase, while the clock sits low, so both edges see it.
    always_ff @(posedge CLK or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            phase    <= PH_LAUNCH;
            bit_cnt  <= 5'h00;
            sclk_int <= 1'b0;
        end else if (next_state != ST_SHIFT) begin
            phase    <= PH_LAUNCH;
            bit_cnt  <= 5'h00;
            sclk_int <= 1'b0;
        end else if (state == ST_SHIFT) begin
            phase    <= phase + 2'h1;
            bit_cnt  <= bit_cnt + {4'h0, bit_end};
            sclk_int <= (phase == PH_LAUNCH) ? 1'b1
                      : (phase == PH_HIGH_END) ? 1'b0 : sclk_int;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // External clock read tracking and overrun.

    logic [4:0] ext_cnt;
    logic       next_overrun;

    wire load_ext = slave & busy_fall;
    // Bits taken but fewer than sixteen means a read was cut short by the new result.
    assign next_overrun = load_ext & (ext_cnt != 5'h00) & (ext_cnt < BIT_COUNT);

    always_ff @(posedge CLK or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            ext_cnt <= 5'h00;
        end else if (load_ext) begin
            ext_cnt <= 5'h00;
        end else if (launch_ext && ext_cnt < BIT_COUNT) begin
            ext_cnt <= ext_cnt + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shift register.

    asop_shift_if sh ();

    assign sh.load      = load_ext | start_int;
    assign sh.load_data = load_ext ? coded : held;
    assign sh.shift     = shift_int | launch_ext;
    assign sh.chain_in  = slave & chain_rdc;

    asop_shifter u_shifter (
        .clk   (CLK),
        .rst_n (rst_n_sync),
        .sh    (sh.shifter)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Registered pin drivers.

    wire [PIN_W-1:0] next_pin_out = serial_mode ? {sh.msb, 4'h0} : held[PAR_HI:PAR_LO];
    wire [PIN_W-1:0] next_pin_oe  = serial_mode ? {read_en, 4'h0} : {PIN_W{read_en}};
    wire             sync_active  = master & (next_state == ST_SHIFT);

    always_ff @(posedge CLK or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            PIN_D_OUT         <= 5'h00;
            PIN_D_OE          <= 5'h00;
            SCLK_OUT          <= 1'b0;
            SCLK_OE           <= 1'b0;
            FRAME_SYNC        <= 1'b0;
            READ_OVERRUN_FLAG <= 1'b0;
        end else begin
            PIN_D_OUT         <= next_pin_out;
            PIN_D_OE          <= next_pin_oe;
            SCLK_OUT          <= master & (sclk_int ^ clk_inv);
            SCLK_OE           <= master;
            FRAME_SYNC        <= serial_mode & (sync_active ^ frm_pol);
            READ_OVERRUN_FLAG <= next_overrun;
        end
    end

endmodule

`default_nettype wire

//--- src/asop_pkg.sv
package asop_pkg;

    // Result word and frame length.
    localparam int          RES_W           = 16;
    localparam logic [4:0]  BIT_COUNT       = 5'h10;
    localparam logic [4:0]  LAST_BIT        = 5'h0F;
    localparam logic [15:0] RESULT_RST      = 16'h0000;

    // Clock and internal bit clock timing.
    localparam int          CLK_PERIOD_NS   = 100;
    localparam int          INT_BIT_NS      = 400;
    localparam int          INT_PHASES      = (INT_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0]  PH_LAUNCH       = 2'h0;
    localparam logic [1:0]  PH_HIGH_END     = 2'h2;
    localparam logic [1:0]  PH_LAST         = 2'(INT_PHASES - 1);

    // Shared pin positions inside the five-pin group (result bits 4 to 8).
    localparam int          PIN_W           = 5;
    localparam int          PIN_CLKSRC      = 0;
    localparam int          PIN_FRMPOL      = 1;
    localparam int          PIN_CLKINV      = 2;
    localparam int          PIN_CHAIN       = 3;
    localparam int          PIN_SERIAL_RESULT_OUT       = 4;
    localparam int          PAR_LO          = 4;
    localparam int          PAR_HI          = 8;

    // Positions inside the synchronised input vector.
    localparam int          SYN_W           = 9;
    localparam int          SYN_PORTSEL     = 4;
    localparam int          SYN_CODE        = 5;
    localparam int          SYN_CS_N        = 6;
    localparam int          SYN_RD_N        = 7;
    localparam int          SYN_SCLK        = 8;
    // Strobes reset inactive (high); the bit clock resets low to match its idle edge detector.
    localparam logic [8:0]  SYN_RST         = 9'h0C0;

    typedef enum logic {
        ST_IDLE  = 1'b0,
        ST_SHIFT = 1'b1
    } asop_state_t;

endpackage

//--- src/asop_shift_if.sv
`timescale 1ns/1ps
`default_nettype none

interface asop_shift_if;
    logic        load;
    logic [15:0] load_data;
    logic        shift;
    logic        chain_in;
    logic        msb;

    modport ctrl    (output load, output load_data, output shift, output chain_in, input msb);
    modport shifter (input load, input load_data, input shift, input chain_in, output msb);
endinterface

`default_nettype wire

//--- src/asop_shifter.sv
`timescale 1ns/1ps
`default_nettype none

module asop_shifter
    import asop_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Control side.
    asop_shift_if.shifter   sh
);

    logic [RES_W-1:0] bits;

    // Load wins over a shift in the same cycle; the chain bit enters at the bottom.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bits <= RESULT_RST;
        end else if (sh.load) begin
            bits <= sh.load_data;
        end else if (sh.shift) begin
            bits <= {bits[RES_W-2:0], sh.chain_in};
        end
    end

    assign sh.msb = bits[RES_W-1];

endmodule

`default_nettype wire

//--- sim/asop_chk.sv
`timescale 1ns/1ps
`default_nettype none

module asop_chk
    import asop_pkg::*;
(
    // Clock, reset and engine.
    input wire logic             CLK,
    input wire logic             RST_N,
    input wire logic             BUSY,
    input wire logic [RES_W-1:0] RESULT,
    // Pins towards the host.
    input wire logic             OUTPUT_CODE_SELECT,
    input wire logic [PIN_W-1:0] PIN_D_OUT,
    input wire logic [PIN_W-1:0] PIN_D_OE,
    input wire logic             SCLK_OUT,
    input wire logic             SCLK_OE,
    input wire logic             READ_OVERRUN_FLAG
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    chk_ovr_pulse: assert property (READ_OVERRUN_FLAG |=> !READ_OVERRUN_FLAG)
        else $error("overrun flag longer than one cycle");
    chk_ovr_cause: assert property (READ_OVERRUN_FLAG |-> !$past(BUSY) && $past(BUSY, 2))
        else $error("overrun flag without a result load");
    chk_idle_clock: assert property (!SCLK_OE |-> !SCLK_OUT)
        else $error("bit clock driven outside master mode");
    chk_serial_pins: assert property (SCLK_OE |-> PIN_D_OE[3:0] == 4'h0)
        else $error("serial input pins driven");
    chk_par_pins: assert property (PIN_D_OE[0] |-> PIN_D_OE == 5'h1F)
        else $error("parallel group partly driven");
    chk_clk_high: assert property ($rose(SCLK_OUT) && SCLK_OE |=> SCLK_OUT)
        else $error("bit clock phase shorter than two cycles");
    chk_data_quiet: assert property (SCLK_OE && $past(SCLK_OE) && $changed(PIN_D_OUT[4])
        |-> $stable(SCLK_OUT))
        else $error("serial data moved on a clock edge");
    chk_par_load: assert property ($fell(BUSY) && PIN_D_OE == 5'h1F
        |-> ##2 PIN_D_OUT == $past(RESULT[8:4], 2))
        else $error("parallel bits wrong after load");
    chk_slave_msb: assert property ($fell(BUSY) && !SCLK_OE && PIN_D_OE == 5'h10
        |-> ##2 PIN_D_OUT[4] == ($past(RESULT[15], 2) ^ !OUTPUT_CODE_SELECT))
        else $error("first serial bit wrong after load");
endmodule

bind asop_top asop_chk chk_u (.CLK(CLK), .RST_N(RST_N), .BUSY(BUSY), .RESULT(RESULT),
    .OUTPUT_CODE_SELECT(OUTPUT_CODE_SELECT), .PIN_D_OUT(PIN_D_OUT), .PIN_D_OE(PIN_D_OE),
    .SCLK_OUT(SCLK_OUT), .SCLK_OE(SCLK_OE), .READ_OVERRUN_FLAG(READ_OVERRUN_FLAG));

`default_nettype wire

//--- sim/asop_host.sv
`timescale 1ns/1ps
`default_nettype none

module asop_host (
    // Bit clock towards the converter.
    output var logic sclk,
    // Serial data as seen on the wire.
    input  wire logic sdata
);
    initial sclk = 1'b0;

    // Parking at the launch level makes the next edge a sampling edge.
    task automatic idle(input logic inv);
        sclk = !inv;
    endtask

    // Sampling before launching keeps the top bit, which is out before any edge.
    task automatic read(input int n, input logic inv, output logic [31:0] w);
        w = 32'h0;
        #37;
        for (int i = 0; i < n; i++) begin
            w = {w[30:0], sdata};
            sclk = inv;
            #400;
            sclk = !inv;
            #400;
        end
    endtask
endmodule

`default_nettype wire

//--- sim/asop_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module asop_top_tb;
    logic clk = 1'b0, rst_n = 1'b0, busy = 1'b0, pts = 1'b1, ocs = 1'b1;
    logic cs_n = 1'b0, rd_n = 1'b0;
    logic [15:0] result = 16'h0000;
    logic [4:0] cfg = 5'h00;
    logic [4:0] d_out, d_oe;
    logic sclk_out, sclk_oe, fsync, ovr, hsclk;
    logic [15:0] wl [4] = '{16'h8E71, 16'h13C6, 16'hF00F, 16'h6A59};
    int errors = 0, checks = 0;
    wire logic [4:0] d_in = (d_oe & d_out) | (~d_oe & cfg);
    wire logic sclk_in = sclk_oe ? sclk_out : hsclk;
    wire logic sdata = d_oe[4] ? d_out[4] : 1'bz;

    asop_host host_u (.sclk(hsclk), .sdata(sdata));

    asop_top dut_u (.CLK(clk), .RST_N(rst_n), .BUSY(busy), .RESULT(result),
        .PORT_TYPE_SELECT(pts), .OUTPUT_CODE_SELECT(ocs), .CS_N(cs_n), .RD_N(rd_n),
        .PIN_D_IN(d_in), .PIN_D_OUT(d_out), .PIN_D_OE(d_oe), .SCLK_IN(sclk_in),
        .SCLK_OUT(sclk_out), .SCLK_OE(sclk_oe), .FRAME_SYNC(fsync),
        .READ_OVERRUN_FLAG(ovr));

    always #50 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // The overrun pulse lasts one cycle, so it is watched on every cycle.
    task automatic fall(input logic [15:0] w, input int n, output logic f);
        result = w;
        busy = 1'b0;
        f = 1'b0;
        repeat (n) begin
            tick(1);
            f = f | ovr;
        end
    endtask

    task automatic conv(input logic [15:0] w, output logic f);
        tick(1);
        busy = 1'b1;
        tick(3);
        fall(w, 4, f);
    endtask

    task automatic mread(input logic inv, input logic pol, input logic [15:0] exp);
        logic [15:0] w;
        logic p;
        int n, t;
        w = 16'h0000;
        p = inv;
        n = 0;
        t = 0;
        while (n < 16) begin
            tick(1);
            t++;
            if (t > 300) begin
                errors++;
                results;
            end
            if (sclk_out !== inv && p === inv) begin
                w = {w[14:0], sdata};
                n++;
                chk(fsync, !pol);
            end
            p = sclk_out;
        end
        chk(w, exp);
        tick(6);
        chk(fsync, pol);
    endtask

    initial begin
        logic f;
        logic [31:0] r;
        tick(8);
        rst_n = 1'b1;
        tick(6);
        for (int k = 0; k < 4; k++) begin
            cfg = {2'h0, k[0], k[1], 1'b0};
            ocs = k[0] ^ k[1];
            tick(4);
            busy = 1'b1;
            tick(8);
            chk(fsync, k[1]);
            fall(wl[k], 0, f);
            mread(k[0], k[1], wl[k] ^ {!ocs, 15'h0});
        end
        chk({sclk_oe, d_oe}, 6'h30);
        cfg[3] = 1'b1;
        tick(4);
        busy = 1'b1;
        mread(1'b1, 1'b1, wl[3] ^ 16'h8000);
        fall(16'h0000, 4, f);
        for (int k = 0; k < 2; k++) begin
            cfg = {1'b0, !k[0], k[0], 2'h1};
            ocs = k[0];
            host_u.idle(k[0]);
            conv(wl[k], f);
            chk(f, 1'b0);
            host_u.read(17, k[0], r);
            chk(r[16:0], {wl[k] ^ {!ocs, 15'h0}, !k[0]});
        end
        chk(d_oe, 5'h10);
        // A fresh load clears the bit count left at sixteen by the full read above.
        conv(wl[3], f);
        chk(f, 1'b0);
        host_u.read(5, 1'b1, r);
        conv(wl[2], f);
        chk(f, 1'b1);
        host_u.read(16, 1'b1, r);
        chk(r[15:0], wl[2]);
        pts = 1'b0;
        tick(4);
        for (int k = 0; k < 2; k++) begin
            conv(wl[k], f);
            chk({d_oe, d_out}, {5'h1F, wl[k][8:4]});
        end
        results;
    end
endmodule

`default_nettype wire
